// [hdl/nvmac_pkg.sv]
package nvmac_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_TPTR = 4'h4;
  localparam logic [3:0] OFF_DATA = 4'h8;
  localparam logic [3:0] OFF_STAT = 4'hC;

  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int BIT_RD     = 0;
  localparam int BIT_WR     = 1;
  localparam int BIT_PERMIT = 2;
  localparam int BIT_ABORT  = 3;
  localparam int BIT_FREE   = 4;
  localparam int BIT_UNUSED = 5;
  localparam int BIT_CFG    = 6;
  localparam int BIT_FLASH  = 7;

  // ----------------------------------------
  // Status register fields
  // ----------------------------------------
  localparam int BIT_BUSY   = 0;
  localparam int BIT_ERASING = 1;

  // ----------------------------------------
  // Reset values and geometry
  // ----------------------------------------
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] DATA_RST  = 8'h00;
  localparam int         ROW_LSB   = 6;
  localparam int         TPTR_W    = 22;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int PROG_TIME_NS  = 2000000;
  localparam int PROG_CYCLES   =
    (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_CNT_W    = 17;

  // ----------------------------------------
  // Memory target codes
  // ----------------------------------------
  localparam logic [1:0] TGT_EEPROM = 2'h0;
  localparam logic [1:0] TGT_FLASH  = 2'h1;
  localparam logic [1:0] TGT_CONFIG = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_PROG = 3'b100
  } nvmac_state_type;

endpackage

// [hdl/nvmac_prog_timer.sv]
module nvmac_prog_timer #(
  parameter int CNT_W = 17
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  // Control
  input  wire logic             i_start,
  input  wire logic [CNT_W-1:0] i_len,
  // Status
  output logic                  o_done
);

  logic [CNT_W-1:0] cnt_r;
  logic             done_r;

  wire logic [CNT_W-1:0] cnt_nxt =
    i_start ? i_len :
    (cnt_r != '0) ? cnt_r - CNT_W'(1) : cnt_r;
  wire logic done_nxt = !i_start && (cnt_r == CNT_W'(1));

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_r  <= '0;
      done_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign o_done = done_r;

endmodule

// [hdl/nvmac_ahb_slave.sv]
module nvmac_ahb_slave (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // AHB-Lite
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic        i_hready,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // Register side
  output logic             o_we,
  output logic [3:0]       o_addr,
  input  wire logic [31:0] i_rdata
);

  logic        we_r;
  logic        hit_r;
  logic        wait_r;
  logic        ready_r;
  logic [3:0]  addr_r;
  logic [31:0] rdata_r;

  // ----------------------------------------
  // Address phase decode
  // ----------------------------------------
  wire logic take    = i_hsel && i_htrans[1] && i_hready;
  wire logic map_hit = (i_haddr[31:4] == 28'h0000000) &&
                       (i_haddr[1:0] == 2'h0);
  wire logic rd_take = take && !i_hwrite;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      we_r    <= 1'b0;
      hit_r   <= 1'b0;
      wait_r  <= 1'b0;
      ready_r <= 1'b1;
      addr_r  <= 4'h0;
      rdata_r <= 32'h00000000;
    end else begin
      we_r    <= take && i_hwrite;
      wait_r  <= rd_take;
      ready_r <= !rd_take;
      if (take) begin
        hit_r  <= map_hit;
        addr_r <= i_haddr[3:0];
      end
      if (wait_r) begin
        rdata_r <= hit_r ? i_rdata : 32'h00000000;
      end
    end
  end

  assign o_we        = we_r && hit_r;
  assign o_addr      = addr_r;
  assign o_hrdata    = rdata_r;
  assign o_hreadyout = ready_r;
  assign o_hresp     = 1'b0;

endmodule

// [hdl/nvmac_top.sv]
// Overview of operation
// - Bit 7 set selects program flash, clear selects data EEPROM.
// - Bit 6 set selects configuration space, overriding bit 7.
// - Bit 5 ignores writes and reads zero.
// - Bit 4 turns next flash write into row erase; clears on completion.
// - Write abort flag sets when reset cuts a write; clears on normal end.
// - Write permit bit gates every write or erase cycle.
// - Write bit starts a self-timed cycle; hardware clears it when done.
// - Software can only set the write bit, never clear it.
// - Read bit starts a one-cycle read; hardware clears it.
// - Read bit cannot be set while flash is selected.
// - Select bits keep their values when a write abort is recorded.
// - Table pointer holds a byte address within program space.
module nvmac_top #(
  parameter int P_PROG_CYCLES = nvmac_pkg::PROG_CYCLES,
  parameter int P_CNT_W       = nvmac_pkg::PROG_CNT_W,
  parameter int P_TPTR_W      = nvmac_pkg::TPTR_W
) (
  // Clock and resets
  input  wire logic                I_REF_CLK,
  input  wire logic                I_RST_N,
  input  wire logic                I_POR_N,
  // AHB-Lite slave
  input  wire logic                I_HSEL,
  input  wire logic [31:0]         I_HADDR,
  input  wire logic [1:0]          I_HTRANS,
  input  wire logic                I_HWRITE,
  input  wire logic [2:0]          I_HSIZE,
  input  wire logic [31:0]         I_HWDATA,
  input  wire logic                I_HREADY,
  output logic      [31:0]         O_HRDATA,
  output logic                     O_HREADYOUT,
  output logic                     O_HRESP,
  // Memory array side
  output logic                     O_MEM_RD_STB,
  output logic                     O_MEM_WR,
  output logic                     O_MEM_ERASE,
  output logic      [1:0]          O_MEM_TARGET,
  output logic      [P_TPTR_W-1:0] O_MEM_ADDR,
  output logic      [7:0]          O_MEM_WDATA,
  input  wire logic [7:0]          I_MEM_RDATA
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  nvmac_pkg::nvmac_state_type st_r;
  nvmac_pkg::nvmac_state_type st_nxt;

  logic                flash_or_eeprom_select_r;
  logic                config_space_select_r;
  logic                free_r;
  logic                write_abort_flag_r;
  logic                write_permit_r;
  logic                erase_op_r;
  logic [P_TPTR_W-1:0] table_pointer_r;
  logic [7:0]          data_r;
  logic                rd_stb_r;
  logic                mem_wr_r;
  logic                mem_erase_r;
  logic [1:0]          target_r;
  logic [P_TPTR_W-1:0] addr_r;
  logic [7:0]          wdata_r;

  logic                bus_we;
  logic [3:0]          bus_addr;
  logic [31:0]         rdata_v;
  logic                tmr_done;

  wire logic all_rst_n = I_RST_N && I_POR_N;
  wire logic warm_rst  = I_POR_N && !I_RST_N;

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  nvmac_ahb_slave u_bus (
    .i_clk       (I_REF_CLK),
    .i_rst_n     (all_rst_n),
    .i_hsel      (I_HSEL),
    .i_haddr     (I_HADDR),
    .i_htrans    (I_HTRANS),
    .i_hwrite    (I_HWRITE),
    .i_hready    (I_HREADY),
    .o_hrdata    (O_HRDATA),
    .o_hreadyout (O_HREADYOUT),
    .o_hresp     (O_HRESP),
    .o_we        (bus_we),
    .o_addr      (bus_addr),
    .i_rdata     (rdata_v)
  );

  // ----------------------------------------
  // Register write decode
  // ----------------------------------------
  wire logic       ctrl_we = bus_we && (bus_addr == nvmac_pkg::OFF_CTRL);
  wire logic       tptr_we = bus_we && (bus_addr == nvmac_pkg::OFF_TPTR);
  wire logic       data_we = bus_we && (bus_addr == nvmac_pkg::OFF_DATA);
  wire logic [7:0] wd      = I_HWDATA[7:0];

  wire logic idle = (st_r == nvmac_pkg::ST_IDLE);
  wire logic prog = (st_r == nvmac_pkg::ST_PROG);
  wire logic rdng = (st_r == nvmac_pkg::ST_READ);

  // Select and erase fields frozen while a cycle runs
  wire logic sel_we = ctrl_we && !prog;
  wire logic flash_nxt = sel_we ? wd[nvmac_pkg::BIT_FLASH]
                                : flash_or_eeprom_select_r;
  wire logic cfg_nxt   = sel_we ? wd[nvmac_pkg::BIT_CFG]
                                : config_space_select_r;
  wire logic permit_nxt = ctrl_we ? wd[nvmac_pkg::BIT_PERMIT]
                                  : write_permit_r;
  wire logic free_wr    = sel_we ? wd[nvmac_pkg::BIT_FREE] : free_r;

  wire logic start_wr = ctrl_we && wd[nvmac_pkg::BIT_WR] &&
                        idle && permit_nxt;

  wire logic start_rd = ctrl_we && wd[nvmac_pkg::BIT_RD] &&
                        !wd[nvmac_pkg::BIT_WR] && idle && !flash_nxt;

  wire logic [1:0] tgt_v = cfg_nxt   ? nvmac_pkg::TGT_CONFIG :
                           flash_nxt ? nvmac_pkg::TGT_FLASH  :
                                       nvmac_pkg::TGT_EEPROM;

  wire logic erase_v = free_wr && (tgt_v == nvmac_pkg::TGT_FLASH);

  wire logic [P_TPTR_W-1:0] row_addr =
    {table_pointer_r[P_TPTR_W-1:nvmac_pkg::ROW_LSB],
     {nvmac_pkg::ROW_LSB{1'b0}}};

  // ----------------------------------------
  // Read data mux
  // ----------------------------------------
  // bit 5 reads zero
  wire logic [7:0] ctrl_rd = {flash_or_eeprom_select_r,
                              config_space_select_r,
                              1'b0,
                              free_r,
                              write_abort_flag_r,
                              write_permit_r,
                              prog,
                              rdng};
  wire logic [7:0] stat_rd = {6'h00, prog && erase_op_r, prog};

  assign rdata_v =
    (bus_addr == nvmac_pkg::OFF_CTRL) ? {24'h000000, ctrl_rd} :
    (bus_addr == nvmac_pkg::OFF_TPTR) ?
      32'(table_pointer_r) :
    (bus_addr == nvmac_pkg::OFF_DATA) ? {24'h000000, data_r} :
    (bus_addr == nvmac_pkg::OFF_STAT) ? {24'h000000, stat_rd} :
                                        32'h00000000;

  // ----------------------------------------
  // Cycle timer
  // ----------------------------------------
  nvmac_prog_timer #(
    .CNT_W (P_CNT_W)
  ) u_tmr (
    .i_clk   (I_REF_CLK),
    .i_rst_n (all_rst_n),
    .i_start (start_wr),
    .i_len   (P_CNT_W'(P_PROG_CYCLES)),
    .o_done  (tmr_done)
  );

  // ----------------------------------------
  // State machine
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      nvmac_pkg::ST_IDLE: begin
        if (start_wr) begin
          st_nxt = nvmac_pkg::ST_PROG;
        end else if (start_rd) begin
          st_nxt = nvmac_pkg::ST_READ;
        end
      end
      nvmac_pkg::ST_READ: begin
        st_nxt = nvmac_pkg::ST_IDLE;
      end
      nvmac_pkg::ST_PROG: begin
        if (tmr_done) begin
          st_nxt = nvmac_pkg::ST_IDLE;
        end
      end
      default: begin
        st_nxt = nvmac_pkg::ST_IDLE;
      end
    endcase
  end

  wire logic done = prog && tmr_done;

  always_ff @(posedge I_REF_CLK) begin
    if (!all_rst_n) begin
      st_r <= nvmac_pkg::ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always_ff @(posedge I_REF_CLK) begin
    if (!I_POR_N) begin
      flash_or_eeprom_select_r <= nvmac_pkg::CTRL_RST[nvmac_pkg::BIT_FLASH];
      config_space_select_r    <= nvmac_pkg::CTRL_RST[nvmac_pkg::BIT_CFG];
      write_abort_flag_r       <= nvmac_pkg::CTRL_RST[nvmac_pkg::BIT_ABORT];
    end else if (!I_RST_N) begin
      write_abort_flag_r <= write_abort_flag_r || prog;
      if (!prog && !write_abort_flag_r) begin
        flash_or_eeprom_select_r <= 1'b0;
        config_space_select_r    <= 1'b0;
      end
    end else begin
      flash_or_eeprom_select_r <= flash_nxt;
      config_space_select_r    <= cfg_nxt;
      if (done) begin
        write_abort_flag_r <= 1'b0;
      end else if (ctrl_we) begin
        write_abort_flag_r <= wd[nvmac_pkg::BIT_ABORT];
      end
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!all_rst_n) begin
      free_r         <= nvmac_pkg::CTRL_RST[nvmac_pkg::BIT_FREE];
      write_permit_r <= nvmac_pkg::CTRL_RST[nvmac_pkg::BIT_PERMIT];
      erase_op_r     <= 1'b0;
    end else begin
      write_permit_r <= permit_nxt;
      if (done && erase_op_r) begin
        free_r <= 1'b0;
      end else begin
        free_r <= free_wr;
      end
      if (start_wr) begin
        erase_op_r <= erase_v;
      end
    end
  end

  // ----------------------------------------
  // Pointer and data latch
  // ----------------------------------------
  always_ff @(posedge I_REF_CLK) begin
    if (!all_rst_n) begin
      table_pointer_r <= '0;
      data_r          <= nvmac_pkg::DATA_RST;
    end else begin
      if (tptr_we && !prog) begin
        table_pointer_r <= I_HWDATA[P_TPTR_W-1:0];
      end
      if (rdng) begin
        data_r <= I_MEM_RDATA;
      end else if (data_we) begin
        data_r <= wd;
      end
    end
  end

  // ----------------------------------------
  // Memory side outputs
  // ----------------------------------------
  always_ff @(posedge I_REF_CLK) begin
    if (!all_rst_n) begin
      rd_stb_r    <= 1'b0;
      mem_wr_r    <= 1'b0;
      mem_erase_r <= 1'b0;
      target_r    <= nvmac_pkg::TGT_EEPROM;
      addr_r      <= '0;
      wdata_r     <= nvmac_pkg::DATA_RST;
    end else begin
      rd_stb_r <= start_rd;
      if (start_wr || start_rd) begin
        target_r <= tgt_v;
        addr_r   <= (start_wr && erase_v) ? row_addr : table_pointer_r;
        wdata_r  <= data_r;
      end
      if (start_wr) begin
        mem_wr_r    <= !erase_v;
        mem_erase_r <= erase_v;
      end else if (done) begin
        mem_wr_r    <= 1'b0;
        mem_erase_r <= 1'b0;
      end
    end
  end

  assign O_MEM_RD_STB = rd_stb_r;
  assign O_MEM_WR     = mem_wr_r;
  assign O_MEM_ERASE  = mem_erase_r;
  assign O_MEM_TARGET = target_r;
  assign O_MEM_ADDR   = addr_r;
  assign O_MEM_WDATA  = wdata_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_flash_target;
    @(posedge I_REF_CLK) disable iff (!all_rst_n)
    (start_wr && !cfg_nxt && flash_nxt) |=> (O_MEM_TARGET == 2'h1);
  endproperty
  a_flash_target: assert property (p_flash_target)
    else $error("flash select did not route to flash");

  property p_cfg_target;
    @(posedge I_REF_CLK) disable iff (!all_rst_n)
    ((start_wr || start_rd) && cfg_nxt) |=> (O_MEM_TARGET == 2'h2);
  endproperty
  a_cfg_target: assert property (p_cfg_target)
    else $error("config select did not route to config space");

  property p_bit5_zero;
    @(posedge I_REF_CLK) disable iff (!all_rst_n)
    (ctrl_we && wd[5]) |=> (ctrl_rd[5] == 1'b0);
  endproperty
  a_bit5_zero: assert property (p_bit5_zero)
    else $error("unimplemented bit read back as one");

  property p_erase_clears;
    @(posedge I_REF_CLK) disable iff (!all_rst_n)
    (O_MEM_ERASE && tmr_done) |=> (!free_r && !O_MEM_ERASE);
  endproperty
  a_erase_clears: assert property (p_erase_clears)
    else $error("erase arm not cleared at completion");

  property p_abort_set;
    @(posedge I_REF_CLK) disable iff (!I_POR_N)
    (warm_rst && prog) |=> write_abort_flag_r;
  endproperty
  a_abort_set: assert property (p_abort_set)
    else $error("reset during write left abort flag clear");

  property p_permit_gate;
    @(posedge I_REF_CLK) disable iff (!all_rst_n)
    ($rose(O_MEM_WR) || $rose(O_MEM_ERASE)) |-> $past(permit_nxt);
  endproperty
  a_permit_gate: assert property (p_permit_gate)
    else $error("write cycle started without permit");

  property p_wr_done;
    @(posedge I_REF_CLK) disable iff (!all_rst_n)
    start_wr |=> (prog && (O_MEM_WR || O_MEM_ERASE)) [*8];
  endproperty
  a_wr_done: assert property (p_wr_done)
    else $error("write cycle ended too early");

  property p_rd_one;
    @(posedge I_REF_CLK) disable iff (!all_rst_n)
    start_rd |=> (rdng && O_MEM_RD_STB) ##1 (!rdng && !O_MEM_RD_STB);
  endproperty
  a_rd_one: assert property (p_rd_one)
    else $error("read did not complete in one cycle");

  property p_rd_refused;
    @(posedge I_REF_CLK) disable iff (!all_rst_n)
    rdng |-> !flash_or_eeprom_select_r;
  endproperty
  a_rd_refused: assert property (p_rd_refused)
    else $error("read started with flash selected");

  property p_sel_kept;
    @(posedge I_REF_CLK) disable iff (!I_POR_N)
    (warm_rst && prog) |=>
      ($stable(flash_or_eeprom_select_r) && $stable(config_space_select_r));
  endproperty
  a_sel_kept: assert property (p_sel_kept)
    else $error("select bits lost on write abort");

  property p_row_align;
    @(posedge I_REF_CLK) disable iff (!all_rst_n)
    O_MEM_ERASE |-> (O_MEM_ADDR[5:0] == 6'h00);
  endproperty
  a_row_align: assert property (p_row_align)
    else $error("erase address not row aligned");

  property p_no_overlap;
    @(posedge I_REF_CLK) disable iff (!all_rst_n)
    (prog && !tmr_done && ctrl_we) |=> (prog && ctrl_rd[1]);
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("write bit dropped while busy");

  property p_no_permit;
    @(posedge I_REF_CLK) disable iff (!all_rst_n)
    (idle && ctrl_we && !wd[2]) |=> !prog;
  endproperty
  a_no_permit: assert property (p_no_permit)
    else $error("cycle started with permit clear");

endmodule

// [verification/nvmac_mem_model.sv]
module nvmac_mem_model (
  // Clock
  input  wire logic        i_clk,
  // Array control
  input  wire logic        i_rd_stb,
  input  wire logic        i_wr,
  input  wire logic        i_erase,
  input  wire logic [1:0]  i_target,
  input  wire logic [21:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  // Array data and activity
  output logic      [7:0]  o_rdata,
  output int               o_wr_cnt,
  output int               o_er_cnt,
  output logic      [21:0] o_er_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [256];
  logic [7:0] last;
  logic       wr_d;
  logic       er_d;
  // ----------------------------------------
  // Array contents
  // ----------------------------------------
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'hA5;
    end
    last = 8'h00;
    wr_d = 1'b0;
    er_d = 1'b0;
    o_wr_cnt = 0;
    o_er_cnt = 0;
    o_er_addr = '0;
  end
  // ----------------------------------------
  // Read data, toggling outside strobe
  // ----------------------------------------
  assign o_rdata = i_rd_stb ? (mem[i_addr[7:0]] ^ {6'h00, i_target})
                            : ~last;
  always @(posedge i_clk) begin
    wr_d <= i_wr;
    er_d <= i_erase;
    last <= o_rdata;
    if (i_wr && !wr_d) begin
      o_wr_cnt <= o_wr_cnt + 1;
      if (i_target == 2'h0) begin
        mem[i_addr[7:0]] <= i_wdata;
      end
    end
    if (i_erase && !er_d) begin
      o_er_cnt <= o_er_cnt + 1;
      o_er_addr <= i_addr;
    end
  end
endmodule

// [verification/test_nvm_access_control.sv]
module test_nvm_access_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        por_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        rd_stb;
  logic        mwr;
  logic        mer;
  logic [1:0]  tgt;
  logic [21:0] maddr;
  logic [7:0]  mwdata;
  logic [7:0]  mrdata;
  logic [21:0] er_addr;
  int          wr_cnt;
  int          er_cnt;
  int          mismatches = 0;
  int          check_count = 0;
  logic [31:0] v;
  // ----------------------------------------
  // Clock and instances
  // ----------------------------------------
  always #10 clk = ~clk;
  nvmac_top #(.P_PROG_CYCLES(10)) uut (
    .I_REF_CLK(clk), .I_RST_N(rst_n), .I_POR_N(por_n),
    .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
    .I_HREADY(hready), .O_HRDATA(hrdata), .O_HREADYOUT(hready),
    .O_HRESP(hresp), .O_MEM_RD_STB(rd_stb), .O_MEM_WR(mwr),
    .O_MEM_ERASE(mer), .O_MEM_TARGET(tgt), .O_MEM_ADDR(maddr),
    .O_MEM_WDATA(mwdata), .I_MEM_RDATA(mrdata));
  nvmac_mem_model mem (
    .i_clk(clk), .i_rd_stb(rd_stb), .i_wr(mwr), .i_erase(mer),
    .i_target(tgt), .i_addr(maddr), .i_wdata(mwdata),
    .o_rdata(mrdata), .o_wr_cnt(wr_cnt), .o_er_cnt(er_cnt),
    .o_er_addr(er_addr));
  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [31:0] a, wd,
                      output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, wd);
    logic [31:0] d;
    xfer(1'b1, a, wd, d);
  endtask
  task automatic chk(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [31:0] a, exp);
    logic [31:0] d;
    xfer(1'b0, a, 32'h0000_0000, d);
    chk(d, exp);
  endtask
  task automatic wait_idle;
    logic [31:0] d;
    int n;
    n = 0;
    do begin
      xfer(1'b0, 32'h0000_0000, 32'h0000_0000, d);
      n++;
    end while (d[1] !== 1'b0 && n < 40);
  endtask
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    complete_run();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    @(posedge clk);
    rchk(32'h0, 32'h00);
    wr(32'h10, 32'hFF);
    rchk(32'h10, 32'h00);
    wr(32'h0, 32'h20);
    rchk(32'h0, 32'h00);
    wr(32'h0, 32'h02);
    rchk(32'h0, 32'h00);
    chk(wr_cnt, 0);
    wr(32'h4, 32'h10);
    wr(32'h0, 32'h01);
    repeat (2) @(posedge clk);
    rchk(32'h0, 32'h00);
    rchk(32'h8, 32'hB5);
    wr(32'h0, 32'h41);
    repeat (2) @(posedge clk);
    rchk(32'h8, 32'hB7);
    wr(32'h0, 32'h81);
    repeat (2) @(posedge clk);
    rchk(32'h0, 32'h80);
    rchk(32'h8, 32'hB7);
    wr(32'h4, 32'h20);
    wr(32'h8, 32'h5A);
    wr(32'h0, 32'h06);
    rchk(32'h0, 32'h06);
    wr(32'h0, 32'h04);
    rchk(32'h0, 32'h06);
    wr(32'h0, 32'h06);
    wait_idle();
    rchk(32'h0, 32'h04);
    chk(wr_cnt, 1);
    wr(32'h0, 32'h01);
    repeat (2) @(posedge clk);
    rchk(32'h8, 32'h5A);
    wr(32'h4, 32'h7F);
    wr(32'h0, 32'h94);
    wr(32'h0, 32'h96);
    rchk(32'hC, 32'h03);
    wait_idle();
    rchk(32'h0, 32'h84);
    chk(er_cnt, 1);
    chk(32'(er_addr), 32'h40);
    chk(wr_cnt, 1);
    wr(32'h0, 32'h86);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rchk(32'h0, 32'h88);
    chk(wr_cnt, 2);
    wr(32'h0, 32'h0E);
    wait_idle();
    rchk(32'h0, 32'h04);
    complete_run();
  end
endmodule
